/* File: design/gosm_defs.svh */
// constants for the pin output source multiplexer
`ifndef GOSM_DEFS_SVH
`define GOSM_DEFS_SVH
`define GOSM_ADDR_PIN0 8'h10
`define GOSM_ADDR_PIN1 8'h11
`define GOSM_CTL_RESET 8'h00
`define GOSM_EN_BIT 0
`define GOSM_VAL_BIT 1
`define GOSM_SRC_LO 2
`define GOSM_SEL_LO 5
`endif

/* File: design/gosm_pkg.sv */
// types for the pin output source multiplexer
package gosm_pkg;
   typedef enum logic [2:0] {
      GOSM_SRC_RX0 = 3'h0,
      GOSM_SRC_RX1 = 3'h1,
      GOSM_SRC_RX2 = 3'h2,
      GOSM_SRC_RX3 = 3'h3,
      GOSM_SRC_DEV = 3'h4,
      GOSM_SRC_R5 = 3'h5,
      GOSM_SRC_TX = 3'h6,
      GOSM_SRC_R7 = 3'h7
   } gosm_src_t;
endpackage : gosm_pkg

/* File: design/gosm_top.sv */
// two-pin output source multiplexer with control registers
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "gosm_defs.svh"
module gosm_top (
   input wire logic sys_clk, // 100 MHz clock
   input wire logic sys_rst, // sync reset, active high
   input wire logic [7:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [7:0] reg_rdata, // read data, cycle after strobe
   input wire logic [15:0] rx_remote_pin, // 4 remote pins per port, port n at [4n+3:4n]
   input wire logic [3:0] rx_lock, // per-port lock
   input wire logic [3:0] rx_pass, // per-port pass
   input wire logic [3:0] rx_frame_valid, // per-port frame valid
   input wire logic [3:0] rx_line_valid, // per-port line valid
   input wire logic [3:0] rx_port_enable, // enabled receive ports
   input wire logic frame_sync_pulse, // internal frame sync
   input wire logic tx_pass_and, // and of selected port pass
   input wire logic tx_pass_or, // or of selected port pass
   input wire logic tx_frame_active, // sending video frame
   input wire logic tx_line_active, // sending video line
   input wire logic tx_synced, // multi-port synchronized
   input wire logic tx_irq, // transmit port interrupt
   output logic pin0_out, // pin 0 output level
   output logic pin0_oe_n, // pin 0 enable, low drives
   output logic pin1_out, // pin 1 output level
   output logic pin1_oe_n // pin 1 enable, low drives
);

   logic [7:0] ctl0_q, ctl0_d, ctl1_q, ctl1_d, rdata_q, rdata_d;
   logic out0_q, out0_d, out1_q, out1_d, oen0_q, oen0_d, oen1_q, oen1_d;

   // selects the level one pin drives from its control byte
   function automatic logic pick(input logic [7:0] ctl, input logic [15:0] rp,
      input logic [3:0] lk, input logic [3:0] ps, input logic [3:0] fv,
      input logic [3:0] lv, input logic [3:0] en, input logic fs,
      input logic [5:0] tx);
      logic [2:0] src;
      logic [2:0] sel;
      logic [1:0] p;
      logic r;
      src = ctl[`GOSM_SRC_LO +: 3];
      sel = ctl[`GOSM_SEL_LO +: 3];
      p = src[1:0];
      r = 1'b0; // reserved codes stay low
      unique case (gosm_pkg::gosm_src_t'(src))
         gosm_pkg::GOSM_SRC_RX0, gosm_pkg::GOSM_SRC_RX1,
         gosm_pkg::GOSM_SRC_RX2, gosm_pkg::GOSM_SRC_RX3:
         begin
            unique case (sel)
               3'h0, 3'h1, 3'h2, 3'h3: r = rp[{p, sel[1:0]}];
               3'h4: r = lk[p];
               3'h5: r = ps[p];
               3'h6: r = fv[p];
               3'h7: r = lv[p];
            endcase
         end
         gosm_pkg::GOSM_SRC_DEV:
         begin
            unique case (sel)
               3'h0: r = ctl[`GOSM_VAL_BIT];
               3'h1: r = |(lk & en);
               3'h2: r = &(ps | ~en);
               3'h4: r = fs;
               default: r = 1'b0;
            endcase
         end
         gosm_pkg::GOSM_SRC_TX:
         begin
            if (sel <= 3'h5)
            begin
               r = tx[sel];
            end
         end
         gosm_pkg::GOSM_SRC_R5, gosm_pkg::GOSM_SRC_R7: r = 1'b0;
      endcase
      return r;
   endfunction : pick

   logic [5:0] tx_vec;
   assign tx_vec = {tx_irq, tx_synced, tx_line_active, tx_frame_active, tx_pass_or, tx_pass_and};

   // register writes, read data and registered pin outputs
   always_comb
   begin
      ctl0_d = ctl0_q;
      ctl1_d = ctl1_q;
      rdata_d = 8'h00; // unmapped reads return zero
      if (reg_wr && reg_addr == `GOSM_ADDR_PIN0)
      begin
         ctl0_d = reg_wdata;
      end
      if (reg_wr && reg_addr == `GOSM_ADDR_PIN1)
      begin
         ctl1_d = reg_wdata;
      end
      if (reg_rd && reg_addr == `GOSM_ADDR_PIN0)
      begin
         rdata_d = ctl0_q;
      end
      if (reg_rd && reg_addr == `GOSM_ADDR_PIN1)
      begin
         rdata_d = ctl1_q;
      end
      // disabled pins also hold low so the level never floats undefined
      oen0_d = ~ctl0_q[`GOSM_EN_BIT];
      oen1_d = ~ctl1_q[`GOSM_EN_BIT];
      out0_d = ctl0_q[`GOSM_EN_BIT] & pick(ctl0_q, rx_remote_pin, rx_lock, rx_pass,
         rx_frame_valid, rx_line_valid, rx_port_enable, frame_sync_pulse, tx_vec);
      out1_d = ctl1_q[`GOSM_EN_BIT] & pick(ctl1_q, rx_remote_pin, rx_lock, rx_pass,
         rx_frame_valid, rx_line_valid, rx_port_enable, frame_sync_pulse, tx_vec);
   end

   // state registers
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ctl0_q <= `GOSM_CTL_RESET;
         ctl1_q <= `GOSM_CTL_RESET;
         rdata_q <= 8'h00;
         out0_q <= 1'b0;
         out1_q <= 1'b0;
         oen0_q <= 1'b1;
         oen1_q <= 1'b1;
      end
      else
      begin
         ctl0_q <= ctl0_d;
         ctl1_q <= ctl1_d;
         rdata_q <= rdata_d;
         out0_q <= out0_d;
         out1_q <= out1_d;
         oen0_q <= oen0_d;
         oen1_q <= oen1_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign pin0_out = out0_q;
   assign pin1_out = out1_q;
   assign pin0_oe_n = oen0_q;
   assign pin1_oe_n = oen1_q;

   // a write to pin 1 control, first step of the enable path
   sequence s_pin1_wr;
      reg_wr && reg_addr == `GOSM_ADDR_PIN1;
   endsequence

   property p_en_follows;
      @(posedge sys_clk) disable iff (sys_rst)
      s_pin1_wr |-> ##2 (pin1_oe_n == ~$past(reg_wdata[0], 2));
   endproperty
   a_en_follows: assert property (p_en_follows) else $error("pin1 enable wrong");

   property p_disabled_low;
      @(posedge sys_clk) disable iff (sys_rst)
      pin0_oe_n |-> !pin0_out;
   endproperty
   a_disabled_low: assert property (p_disabled_low) else $error("disabled pin0 not low");

   property p_local_level;
      @(posedge sys_clk) disable iff (sys_rst)
      (ctl1_q[4:0] == 5'b10011 && ctl1_q[7:5] == 3'h0) |=> pin1_out;
   endproperty
   a_local_level: assert property (p_local_level) else $error("local level not driven");

   property p_reserved_src;
      @(posedge sys_clk) disable iff (sys_rst)
      (ctl0_q[4:2] == 3'h5 || ctl0_q[4:2] == 3'h7) |=> !pin0_out;
   endproperty
   a_reserved_src: assert property (p_reserved_src) else $error("reserved source not low");

   property p_rx_lock;
      @(posedge sys_clk) disable iff (sys_rst)
      (ctl1_q[0] && ctl1_q[4:2] == 3'h2 && ctl1_q[7:5] == 3'h4) |=> pin1_out == $past(rx_lock[2]);
   endproperty
   a_rx_lock: assert property (p_rx_lock) else $error("rx lock select wrong");

   property p_dev_fsync;
      @(posedge sys_clk) disable iff (sys_rst)
      (ctl0_q[0] && ctl0_q[7:2] == 6'b100100) |=> pin0_out == $past(frame_sync_pulse);
   endproperty
   a_dev_fsync: assert property (p_dev_fsync) else $error("frame sync select wrong");

   property p_dev_or;
      @(posedge sys_clk) disable iff (sys_rst)
      (ctl0_q[0] && ctl0_q[7:2] == 6'b001100) |=>
         pin0_out == |($past(rx_lock) & $past(rx_port_enable));
   endproperty
   a_dev_or: assert property (p_dev_or) else $error("lock or wrong");

   property p_tx_irq;
      @(posedge sys_clk) disable iff (sys_rst)
      (ctl1_q[0] && ctl1_q[7:2] == 6'b101110) |=> pin1_out == $past(tx_irq);
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("tx irq select wrong");

   property p_src0_rx;
      @(posedge sys_clk) disable iff (sys_rst)
      (ctl0_q[0] && ctl0_q[7:2] == 6'b011001) |=> pin0_out == $past(rx_remote_pin[7]);
   endproperty
   a_src0_rx: assert property (p_src0_rx) else $error("pin0 remote pin wrong");

   property p_rd;
      @(posedge sys_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == `GOSM_ADDR_PIN1) |=> reg_rdata == $past(ctl1_q);
   endproperty
   a_rd: assert property (p_rd) else $error("readback wrong");

   property p_dev_and;
      @(posedge sys_clk) disable iff (sys_rst)
      (ctl0_q[0] && ctl0_q[7:2] == 6'b010100) |=>
         pin0_out == (($past(rx_pass) & $past(rx_port_enable)) == $past(rx_port_enable));
   endproperty
   a_dev_and: assert property (p_dev_and) else $error("pass and wrong");

   property p_tx_pass_and;
      @(posedge sys_clk) disable iff (sys_rst)
      (ctl0_q[0] && ctl0_q[7:2] == 6'b000110) |=> pin0_out == $past(tx_pass_and);
   endproperty
   a_tx_pass_and: assert property (p_tx_pass_and) else $error("tx pass and wrong");

   property p_dev_resv;
      @(posedge sys_clk) disable iff (sys_rst)
      (ctl0_q[4:2] == 3'h4 && ctl0_q[7:5] >= 3'h5) |=> !pin0_out;
   endproperty
   a_dev_resv: assert property (p_dev_resv) else $error("reserved selector not low");

   property p_src1_rx;
      @(posedge sys_clk) disable iff (sys_rst)
      (ctl1_q[0] && ctl1_q[7:2] == 6'b111011) |=> pin1_out == $past(rx_line_valid[3]);
   endproperty
   a_src1_rx: assert property (p_src1_rx) else $error("pin1 line valid wrong");

   // no disable here: this one watches the reset itself
   property p_reset_off;
      @(posedge sys_clk)
      sys_rst |=> (pin0_oe_n && pin1_oe_n && !pin0_out && !pin1_out);
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("pins not off after reset");

endmodule : gosm_top
`default_nettype wire

/* File: tb/gosm_board.sv */
// board-side load on one output pin
`timescale 1ns/10ps
`default_nettype none
module gosm_board (
   input wire logic sys_clk, // bench clock
   input wire logic pin_out, // level from the device
   input wire logic pin_oe_n, // low while the device drives
   output logic pin_level // level seen on the board
);
   logic last_q = 1'b0;
   // no pull on this net, so a released pin shows the inverse of its last level
   always @(posedge sys_clk)
      if (!pin_oe_n)
         last_q <= pin_out;
   assign pin_level = pin_oe_n ? ~last_q : pin_out;
endmodule : gosm_board
`default_nettype wire

/* File: tb/tb_top.sv */
// random and corner tests of the pin output source multiplexer
`timescale 1ns/10ps
`default_nettype none
`include "gosm_defs.svh"
module tb_top;
   logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, m0 = 8'h00, m1 = 8'h00, d1;
   logic [42:0] stim = '0;
   logic [1:0] e0 = 2'h2, e1 = 2'h2;
   logic pin0_out, pin0_oe_n, pin1_out, pin1_oe_n, lvl0, lvl1;
   logic [31:0] rs = 32'h77c3;
   logic [7:0] corner [5] = '{8'h13, 8'h8b, 8'hbb, 8'hed, 8'h17};
   int error_cnt = 0, num_checks = 0, cyc = 0;
   always #5 sys_clk = ~sys_clk;
   gosm_top gosm_top_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rx_remote_pin(stim[15:0]), .rx_lock(stim[19:16]), .rx_pass(stim[23:20]),
      .rx_frame_valid(stim[27:24]), .rx_line_valid(stim[31:28]), .rx_port_enable(stim[35:32]),
      .frame_sync_pulse(stim[36]), .tx_pass_and(stim[37]), .tx_pass_or(stim[38]),
      .tx_frame_active(stim[39]), .tx_line_active(stim[40]), .tx_synced(stim[41]),
      .tx_irq(stim[42]), .pin0_out(pin0_out), .pin0_oe_n(pin0_oe_n), .pin1_out(pin1_out),
      .pin1_oe_n(pin1_oe_n));
   gosm_board gosm_board_inst (.sys_clk(sys_clk), .pin_out(pin0_out), .pin_oe_n(pin0_oe_n),
      .pin_level(lvl0));
   gosm_board gosm_board_inst1 (.sys_clk(sys_clk), .pin_out(pin1_out), .pin_oe_n(pin1_oe_n),
      .pin_level(lvl1));
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : xs
   // expected {oe_n, out} from a control value and the input levels
   function automatic logic [1:0] f(input logic [7:0] c, input logic [42:0] v);
      logic [2:0] s, k;
      logic o;
      s = c[4:2];
      k = c[7:5];
      o = 1'b0;
      if (s < 4)
         o = (k < 4) ? v[4 * s + k] : v[16 + 4 * (k - 4) + s];
      else if (s == 4)
         case (k)
            3'h0: o = c[1];
            3'h1: o = (v[19:16] & v[35:32]) != 4'h0;
            3'h2: o = (v[23:20] & v[35:32]) == v[35:32];
            3'h4: o = v[36];
            default: o = 1'b0;
         endcase
      else if (s == 6 && k < 6)
         o = v[37 + k];
      return c[0] ? {1'b0, o} : 2'h2;
   endfunction : f
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task finish_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk("rdata", e, reg_rdata);
   endtask : rd
   // mirror of the control registers, pin outputs lag their causes by one edge
   always @(posedge sys_clk)
   begin
      if (run)
      begin
         chk("pin0", {6'h0, e0}, {6'h0, pin0_oe_n, pin0_out});
         chk("pin1", {6'h0, e1}, {6'h0, pin1_oe_n, pin1_out});
         if (!e0[1])
            chk("level0", {7'h0, e0[0]}, {7'h0, lvl0});
         if (!e1[1])
            chk("level1", {7'h0, e1[0]}, {7'h0, lvl1});
      end
      stim <= 43'({xs(), xs()});
      if (sys_rst)
      begin
         {m0, m1, e0, e1} <= {16'h0, 4'ha};
      end
      else
      begin
         e0 <= f(m0, stim);
         e1 <= f(m1, stim);
         if (reg_wr && reg_addr == `GOSM_ADDR_PIN0)
            m0 <= reg_wdata;
         if (reg_wr && reg_addr == `GOSM_ADDR_PIN1)
            m1 <= reg_wdata;
      end
      cyc++;
      if (cyc == 12000)
      begin
         error_cnt++;
         finish_test();
      end
   end
   initial
   begin
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'b0;
      run <= 1'b1;
      rd(`GOSM_ADDR_PIN0, `GOSM_CTL_RESET);
      rd(`GOSM_ADDR_PIN1, `GOSM_CTL_RESET);
      $display("test reset done");
      // every code of both fields, enable and level on pin 0, random on pin 1
      for (int i = 0; i < 256; i++)
      begin
         d1 = stim[7:0];
         wr(`GOSM_ADDR_PIN0, i[7:0]);
         wr(`GOSM_ADDR_PIN1, d1);
         rd(`GOSM_ADDR_PIN0, i[7:0]);
         rd(`GOSM_ADDR_PIN1, d1);
         repeat (4) @(posedge sys_clk);
      end
      $display("test codes done");
      // hand-picked pin 1 codes that the random loop may miss
      for (int j = 0; j < 5; j++)
      begin
         d1 = corner[j];
         wr(`GOSM_ADDR_PIN1, d1);
         rd(`GOSM_ADDR_PIN1, d1);
         repeat (4) @(posedge sys_clk);
      end
      $display("test corners done");
      wr(8'h12, 8'hff);
      rd(8'h12, 8'h00);
      rd(`GOSM_ADDR_PIN0, 8'hff);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(`GOSM_ADDR_PIN1, `GOSM_CTL_RESET);
      $display("test unmapped and reset done");
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
